// *** design/zscs_pkg.sv ***
// Shared constants and types for the zero/span calibration sequencer.
// Assumes one 50 MHz clock and a time-of-day clock on that clock.
package zscs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int ZSCS_CLK_HZ = 50_000_000;
	localparam int ZSCS_QUAL_TIME_S = 5;
	// Least time, so whole cycles; 250,000,000 fits in 32 bits
	localparam int ZSCS_QUAL_CYCLES = ZSCS_QUAL_TIME_S * ZSCS_CLK_HZ;

	// ----------------------------------------
	// Sizes and reset values
	// ----------------------------------------
	localparam int ZSCS_NUM_SEQ = 3;
	localparam int ZSCS_NUM_CONTACT = 3;
	localparam int ZSCS_MIN_W = 16;
	localparam logic [2:0] ZSCS_STEPS_NONE = 3'h0;

	// Operating mode; contact index is mode minus one
	typedef enum logic [1:0] {
		ZSCS_SAMPLE = 2'b00,
		ZSCS_ZERO = 2'b01,
		ZSCS_LOW = 2'b10,
		ZSCS_HIGH = 2'b11
	} zscs_mode_t;

	// Who started the step in progress
	typedef enum logic [1:0] {
		ZSCS_SRC_NONE = 2'b00,
		ZSCS_SRC_CONTACT = 2'b01,
		ZSCS_SRC_SCHED = 2'b10,
		ZSCS_SRC_COM = 2'b11
	} zscs_src_t;

	// Time of day as kept by the internal clock
	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
	} zscs_tod_t;

	// One programmed sequence
	typedef struct packed {
		logic enabled;
		logic calibrate;
		logic zero;
		logic low;
		logic high;
		zscs_tod_t sequence_first_run_time;
		logic [ZSCS_MIN_W-1:0] interval_min;
		logic [ZSCS_MIN_W-1:0] duration_min;
	} zscs_seq_cfg_t;

	// Valve drive; all clear is the sample path
	typedef struct packed {
		logic zero_sel;
		logic low_span_sel;
		logic high_span_sel;
	} zscs_valve_t;

	localparam zscs_valve_t ZSCS_VALVE_SAMPLE = 3'h0;

endpackage

// *** design/zscs_seq_timer.sv ***
// One scheduled sequence: first run at its start date and time, then
// every interval minutes. Assumes tod and minute_tick share clk.
`timescale 1ns/1ps

module zscs_seq_timer import zscs_pkg::*; (
	input wire logic clk,
	input wire logic rst_sync_b,
	input wire zscs_seq_cfg_t cfg,
	input wire zscs_tod_t tod,
	input wire logic minute_tick,
	output logic fire
);

	typedef struct packed {
		logic started;
		logic [ZSCS_MIN_W-1:0] wait_min;
		logic fire;
	} zscs_tmr_st_t;

	zscs_tmr_st_t st;
	zscs_tmr_st_t next_st;

	// ----------------------------------------
	// Schedule
	// ----------------------------------------
	// Clearing enable disarms, so re-enabling waits for the start time again
	always_comb begin
		next_st = st;
		next_st.fire = 1'b0;
		if (!cfg.enabled) begin
			next_st.started = 1'b0;
			next_st.wait_min = '0;
		end else if (minute_tick) begin
			if (!st.started) begin
				if (tod == cfg.sequence_first_run_time) begin
					next_st.fire = 1'b1;
					next_st.started = 1'b1;
					next_st.wait_min = cfg.interval_min;
				end
			end else if (cfg.interval_min != '0) begin
				// Zero interval means run once only
				if (st.wait_min <= ZSCS_MIN_W'(1)) begin
					next_st.fire = 1'b1;
					next_st.wait_min = cfg.interval_min;
				end else begin
					next_st.wait_min = st.wait_min - ZSCS_MIN_W'(1);
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign fire = st.fire;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	disabled_never_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
		!cfg.enabled |=> !fire)
		else $error("Disabled sequence fired");

	first_run_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(cfg.enabled && !st.started && minute_tick && tod != cfg.sequence_first_run_time) |=> !fire)
		else $error("Sequence fired before its start time");

endmodule // zscs_seq_timer

// *** design/zscs_sequencer.sv ***
// Zero/span calibration sequencer: contact inputs, three scheduled
// sequences and a port command drive the mode and valve outputs.
// Assumes contacts are raw pins; everything else is on clk.
//
// Behaviour
// - Contact closed five seconds enters its mode
// - Contacts accepted in any order
// - Mode held while its contact stays closed
// - Calibrate flag: record values when contact opens
// - Flag clear: return to sample, no record
// - Schedule runs from time-of-day clock
// - Three independent programmed sequences
// - Each sequence zero, low, high or disabled
// - Calibrate flag selects calibration versus check
// - Zero flag gives zero calibration or check
// - Zero check only when enabled, uncalibrated
// - Low flag gives low-span calibration or check
// - High flag gives high-span calibration or check
// - First run at programmed date and time
// - Interval minutes between successive runs
// - Each step of a run lasts programmed duration minutes
// - New initiation overrides sequence in progress
`timescale 1ns/1ps

module zscs_sequencer import zscs_pkg::*; #(
	parameter int QUAL_CYCLES = ZSCS_QUAL_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ZSCS_NUM_CONTACT-1:0] contact_in,
	input wire logic contact_cal_flag,
	input wire zscs_seq_cfg_t [ZSCS_NUM_SEQ-1:0] seq_cfg,
	input wire zscs_tod_t tod,
	input wire logic minute_tick,
	input wire logic com_start,
	input wire zscs_mode_t com_mode,
	input wire logic com_calibrate,
	input wire logic com_stop,
	output zscs_mode_t mode,
	output zscs_src_t source,
	output logic is_check,
	output logic cal_record,
	output zscs_valve_t valve
);

	localparam int QW = $clog2(QUAL_CYCLES + 1);
	localparam logic [QW-1:0] QUAL_FULL = QW'(QUAL_CYCLES);
	localparam logic [QW-1:0] QUAL_LAST = QW'(QUAL_CYCLES - 1);

	typedef struct packed {
		logic [ZSCS_NUM_CONTACT-1:0] sync1;
		logic [ZSCS_NUM_CONTACT-1:0] sync2;
		logic [ZSCS_NUM_CONTACT-1:0][QW-1:0] qual;
		zscs_mode_t mode;
		zscs_src_t src;
		logic cal;
		logic [2:0] steps_left;
		logic [ZSCS_MIN_W-1:0] dur_left;
		logic [ZSCS_MIN_W-1:0] dur_load;
		logic cal_record;
		zscs_valve_t valve;
	} zscs_main_st_t;

	logic [1:0] rst_pipe;
	logic rst_sync_b;
	zscs_main_st_t st;
	zscs_main_st_t next_st;
	logic [ZSCS_NUM_SEQ-1:0] seq_fire;
	logic [ZSCS_NUM_CONTACT-1:0] closed;
	logic [ZSCS_NUM_CONTACT-1:0] qual_hit;
	logic [1:0] cur_idx;
	logic any_init;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Assert at once, release two edges later so no flop sees a runt
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_sync_b = rst_pipe[1];

	// ----------------------------------------
	// Scheduled sequences
	// ----------------------------------------
	// One timer per sequence, each fully independent
	for (genvar g = 0; g < ZSCS_NUM_SEQ; g++) begin : g_seq
		zscs_seq_timer u_timer (
			.clk(clk),
			.rst_sync_b(rst_sync_b),
			.cfg(seq_cfg[g]),
			.tod(tod),
			.minute_tick(minute_tick),
			.fire(seq_fire[g])
		);
	end

	// Picks the first selected step, zero before low before high
	function automatic zscs_mode_t first_step(input logic [2:0] steps);
		zscs_mode_t m;
		m = ZSCS_SAMPLE;
		if (steps[0]) begin
			m = ZSCS_ZERO;
		end else if (steps[1]) begin
			m = ZSCS_LOW;
		end else if (steps[2]) begin
			m = ZSCS_HIGH;
		end
		return m;
	endfunction

	// Contact qualification works on the second synchroniser stage only
	assign closed = st.sync2;
	// Index of the running step; meaningless in SAMPLE, so read only while a step runs
	assign cur_idx = 2'(st.mode) - 2'h1;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Endings first, then initiations; later assignments win, so any new
	// initiation overrides what is in progress and an overridden step
	// records nothing.
	always_comb begin
		logic [2:0] steps;
		steps = ZSCS_STEPS_NONE;
		next_st = st;
		next_st.cal_record = 1'b0;
		next_st.sync1 = contact_in;
		next_st.sync2 = st.sync1;
		qual_hit = '0;
		any_init = 1'b0;

		// Per-contact hold timers, reset by any opening
		for (int i = 0; i < ZSCS_NUM_CONTACT; i++) begin
			if (!closed[i]) begin
				next_st.qual[i] = '0;
			end else if (st.qual[i] != QUAL_FULL) begin
				next_st.qual[i] = st.qual[i] + QW'(1);
				qual_hit[i] = (st.qual[i] == QUAL_LAST);
			end
		end

		// End of the step in progress
		unique case (st.src)
			ZSCS_SRC_NONE: begin
			end
			ZSCS_SRC_CONTACT: begin
				if (!closed[cur_idx]) begin
					next_st.cal_record = st.cal;
					next_st.src = ZSCS_SRC_NONE;
					next_st.mode = ZSCS_SAMPLE;
				end
			end
			ZSCS_SRC_SCHED: begin
				if (minute_tick) begin
					if (st.dur_left <= ZSCS_MIN_W'(1)) begin
						next_st.cal_record = st.cal;
						steps = st.steps_left & ~(3'h1 << cur_idx);
						next_st.steps_left = steps;
						next_st.mode = first_step(steps);
						next_st.dur_left = st.dur_load;
						if (steps == ZSCS_STEPS_NONE) begin
							next_st.src = ZSCS_SRC_NONE;
						end
					end else begin
						next_st.dur_left = st.dur_left - ZSCS_MIN_W'(1);
					end
				end
			end
			ZSCS_SRC_COM: begin
				if (com_stop) begin
					next_st.cal_record = st.cal;
					next_st.src = ZSCS_SRC_NONE;
					next_st.mode = ZSCS_SAMPLE;
				end
			end
		endcase

		// Port command
		if (com_start && com_mode != ZSCS_SAMPLE) begin
			any_init = 1'b1;
			next_st.src = ZSCS_SRC_COM;
			next_st.mode = com_mode;
			next_st.cal = com_calibrate;
		end

		// Scheduled runs; lowest sequence number wins a tie
		for (int j = ZSCS_NUM_SEQ - 1; j >= 0; j--) begin
			steps = {seq_cfg[j].high, seq_cfg[j].low, seq_cfg[j].zero};
			if (seq_fire[j] && seq_cfg[j].enabled && steps != ZSCS_STEPS_NONE) begin
				any_init = 1'b1;
				next_st.src = ZSCS_SRC_SCHED;
				next_st.steps_left = steps;
				next_st.mode = first_step(steps);
				next_st.cal = seq_cfg[j].calibrate;
				next_st.dur_left = seq_cfg[j].duration_min;
				next_st.dur_load = seq_cfg[j].duration_min;
			end
		end

		// Contacts; zero before low before high on a tie
		for (int k = ZSCS_NUM_CONTACT - 1; k >= 0; k--) begin
			if (qual_hit[k]) begin
				any_init = 1'b1;
				next_st.src = ZSCS_SRC_CONTACT;
				next_st.mode = zscs_mode_t'(2'(k + 1));
				next_st.cal = contact_cal_flag;
			end
		end

		// Valves follow the mode, sample path when idle
		next_st.valve = ZSCS_VALVE_SAMPLE;
		next_st.valve.zero_sel = (next_st.mode == ZSCS_ZERO);
		next_st.valve.low_span_sel = (next_st.mode == ZSCS_LOW);
		next_st.valve.high_span_sel = (next_st.mode == ZSCS_HIGH);
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign mode = st.mode;
	assign source = st.src;
	assign is_check = (st.src != ZSCS_SRC_NONE) && !st.cal;
	assign cal_record = st.cal_record;
	assign valve = st.valve;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	// Judged on the hit itself, since the counter index moves with the mode
	contact_entry_a: assert property (
		(qual_hit == '0) |=> !(source == ZSCS_SRC_CONTACT && ($changed(source) || $changed(mode))))
		else $error("Contact mode entered before full qualification");

	contact_hold_a: assert property (
		(st.src == ZSCS_SRC_CONTACT && closed[cur_idx] && !any_init) |=> $stable(st.mode) && st.src == ZSCS_SRC_CONTACT)
		else $error("Contact mode left while contact closed");

	cal_on_open_a: assert property (
		(st.src == ZSCS_SRC_CONTACT && !closed[cur_idx] && st.cal) |=> cal_record)
		else $error("Calibration not recorded on contact opening");

	check_open_a: assert property (
		(st.src == ZSCS_SRC_CONTACT && !closed[cur_idx] && !st.cal && !any_init)
		|=> !cal_record && mode == ZSCS_SAMPLE)
		else $error("Check mode changed calibration or stayed active");

	valve_match_a: assert property (
		valve == {mode == ZSCS_ZERO, mode == ZSCS_LOW, mode == ZSCS_HIGH})
		else $error("Valves disagree with mode");

	sched_override_a: assert property (
		(seq_fire[0] && seq_cfg[0].enabled && (seq_cfg[0].zero || seq_cfg[0].low || seq_cfg[0].high)
		&& qual_hit == '0) |=> source == ZSCS_SRC_SCHED)
		else $error("Scheduled run did not take over");

	sched_end_a: assert property (
		(st.src == ZSCS_SRC_SCHED && minute_tick && st.dur_left <= ZSCS_MIN_W'(1)
		&& st.steps_left == (3'h1 << cur_idx) && !any_init) |=> mode == ZSCS_SAMPLE ##0 valve == ZSCS_VALVE_SAMPLE)
		else $error("Expired run did not restore sample");

	check_flag_a: assert property (
		(seq_fire[0] && seq_cfg[0].enabled && (seq_cfg[0].zero || seq_cfg[0].low || seq_cfg[0].high)
		&& qual_hit == '0) |=> is_check == !$past(seq_cfg[0].calibrate))
		else $error("Check indication does not follow the calibrate flag");

	short_contact_a: assert property (
		(st.src == ZSCS_SRC_NONE && !any_init) |=> mode == ZSCS_SAMPLE)
		else $error("Mode changed without initiation");

	contact_any_a: assert property (
		(qual_hit[2] && qual_hit[1:0] == 2'h0) |=> mode == ZSCS_HIGH && source == ZSCS_SRC_CONTACT)
		else $error("High-span contact not taken from the current state");

	// Main scenarios: contact run, scheduled run and check, override, port run
	contact_cal_c: cover property (st.src == ZSCS_SRC_CONTACT && st.cal ##[1:1000] cal_record);
	sched_run_c: cover property (st.src == ZSCS_SRC_SCHED ##1 st.src == ZSCS_SRC_NONE);
	override_c: cover property (st.src == ZSCS_SRC_SCHED ##1 st.src == ZSCS_SRC_CONTACT);
	com_run_c: cover property (st.src == ZSCS_SRC_COM ##1 st.src == ZSCS_SRC_NONE);
	sched_check_c: cover property (st.src == ZSCS_SRC_SCHED && !st.cal ##1 st.src == ZSCS_SRC_NONE);

endmodule // zscs_sequencer

// *** testbench/zscs_far_model.sv ***
// Far side: remote contact closures and the zero/span valve actuators.
// Assumes requests change just after a rising edge of clk.
`timescale 1ns/1ps

module zscs_far_model import zscs_pkg::*; (
	input wire logic clk,
	input wire logic [2:0] close_req,
	input wire zscs_valve_t valve,
	output logic [2:0] contact_in,
	output logic valve_fault
);
	// Contacts start open; a closure stays until the controller lets go
	initial contact_in = 3'h0;
	initial valve_fault = 1'b0;
	always @(posedge clk) begin
		contact_in <= close_req;
	end
	// Two gas paths open at once would mix zero air and span gas
	always @(posedge clk) begin
		if ($countones(valve) > 1) begin
			valve_fault <= 1'b1;
		end
	end
endmodule // zscs_far_model

// *** testbench/zero_span_cal_sequencer_tb_top.sv ***
// Self-checking bench for the calibration sequencer: contacts, schedule
// and port override. Assumes a short qualification count of 20 cycles.
`timescale 1ns/1ps

module zero_span_cal_sequencer_tb_top import zscs_pkg::*;;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] close_req = 3'h0;
	logic [2:0] contact_in;
	logic contact_cal_flag = 1'b0;
	zscs_seq_cfg_t [ZSCS_NUM_SEQ-1:0] seq_cfg = '0;
	zscs_tod_t tod = '0;
	logic minute_tick = 1'b0;
	logic com_start = 1'b0;
	zscs_mode_t com_mode = ZSCS_SAMPLE;
	logic com_calibrate = 1'b0;
	logic com_stop = 1'b0;
	zscs_mode_t mode;
	zscs_src_t source;
	logic is_check;
	logic cal_record;
	zscs_valve_t valve;
	logic valve_fault;
	int n_fail = 0;
	int comparisons = 0;
	int n_rec = 0;
	int cyc = 0;

	zscs_sequencer #(.QUAL_CYCLES(20)) u_zscs_sequencer (.clk(clk), .rst_b(rst_b), .contact_in(contact_in),
		.contact_cal_flag(contact_cal_flag), .seq_cfg(seq_cfg), .tod(tod), .minute_tick(minute_tick),
		.com_start(com_start), .com_mode(com_mode), .com_calibrate(com_calibrate), .com_stop(com_stop),
		.mode(mode), .source(source), .is_check(is_check), .cal_record(cal_record), .valve(valve));
	zscs_far_model u_zscs_far_model (.clk(clk), .close_req(close_req), .valve(valve),
		.contact_in(contact_in), .valve_fault(valve_fault));

	always #10 clk = ~clk;

	// Count record pulses; a pulse stands one cycle so each edge sees it once
	always @(posedge clk) begin
		if (cal_record === 1'b1) begin
			n_rec <= n_rec + 1;
		end
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			end_sim();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("Counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Bounded wait, sampled at the falling edge where outputs have settled
	task automatic wait_mode(input zscs_mode_t m, output int n);
		n = 0;
		while (mode !== m && n < 200) begin
			@(negedge clk);
			n++;
		end
	endtask

	// Advance the time of day by k minutes, one tick pulse each
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge clk);
			tod.minute <= tod.minute + 6'h01;
			minute_tick <= 1'b1;
			@(posedge clk);
			minute_tick <= 1'b0;
			repeat (4) @(posedge clk);
		end
		@(negedge clk);
	endtask

	// Close one contact, hold it, open it; exp is {mode, source, valve, is_check}
	task automatic contact_run(input logic [2:0] pins, input logic cal, input logic [7:0] exp);
		int n;
		int r;
		r = n_rec;
		@(posedge clk);
		close_req <= pins;
		contact_cal_flag <= cal;
		@(negedge clk);
		wait_mode(zscs_mode_t'(exp[7:6]), n);
		check(8'(n >= 20 && n <= 26), 8'h01);
		check({mode, source, valve, is_check}, exp);
		repeat (40) @(negedge clk);
		check({mode, source, valve, is_check}, exp);
		@(posedge clk);
		close_req <= 3'h0;
		wait_mode(ZSCS_SAMPLE, n);
		repeat (3) @(negedge clk);
		check(8'(n_rec - r), 8'(cal));
		check({mode, source, valve, is_check}, 8'h00);
	endtask

	function automatic logic [7:0] st(input zscs_mode_t m, input zscs_src_t s, input logic [2:0] v, input logic c);
		return {m, s, v, c};
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int r;
		// Starts lie at least five minutes after the clock's minute 5
		tod.minute = 6'h05;
		// Enabled sequences start at different minutes
		seq_cfg[0] = {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 27'h000000A, 16'h0006, 16'h0002};
		// Disabled twin shares the start of sequence three only to prove it stays quiet
		seq_cfg[1] = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 27'h0000028, 16'h0000, 16'h0001};
		seq_cfg[2] = {1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 27'h0000028, 16'h0000, 16'h0001};
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(negedge clk);
		check({mode, source, valve, is_check}, 8'h00);
		// Short closure must be ignored
		@(posedge clk);
		close_req <= 3'h1;
		repeat (15) @(posedge clk);
		close_req <= 3'h0;
		repeat (30) @(negedge clk);
		check({mode, source, valve, is_check}, 8'h00);
		check(8'(n_rec), 8'h00);
		$display("test short closure done");
		contact_run(3'h1, 1'b1, st(ZSCS_ZERO, ZSCS_SRC_CONTACT, 3'h4, 1'b0));
		contact_run(3'h4, 1'b0, st(ZSCS_HIGH, ZSCS_SRC_CONTACT, 3'h1, 1'b1));
		contact_run(3'h2, 1'b0, st(ZSCS_LOW, ZSCS_SRC_CONTACT, 3'h2, 1'b1));
		$display("test contacts done");
		r = n_rec;
		tick(4);
		check({mode, source, valve, is_check}, 8'h00);
		tick(1);
		check({mode, source, valve, is_check}, st(ZSCS_ZERO, ZSCS_SRC_SCHED, 3'h4, 1'b0));
		tick(1);
		check(8'(mode), 8'(ZSCS_ZERO));
		tick(1);
		check({mode, source, valve, is_check}, st(ZSCS_LOW, ZSCS_SRC_SCHED, 3'h2, 1'b0));
		tick(2);
		check({mode, source, valve, is_check}, 8'h00);
		check(8'(n_rec - r), 8'h02);
		tick(1);
		check(8'(mode), 8'(ZSCS_SAMPLE));
		tick(1);
		check(8'(mode), 8'(ZSCS_ZERO));
		$display("test schedule done");
		// Port step with calibrate set; the overridden scheduled step must record nothing
		r = n_rec;
		@(posedge clk);
		com_start <= 1'b1;
		com_mode <= ZSCS_HIGH;
		com_calibrate <= 1'b1;
		@(posedge clk);
		com_start <= 1'b0;
		seq_cfg[0].enabled <= 1'b0;
		@(negedge clk);
		check({mode, source, valve, is_check}, st(ZSCS_HIGH, ZSCS_SRC_COM, 3'h1, 1'b0));
		@(posedge clk);
		com_stop <= 1'b1;
		@(posedge clk);
		com_stop <= 1'b0;
		@(negedge clk);
		check({mode, source, valve, is_check}, 8'h00);
		// The record pulse is counted one edge after it stands
		@(negedge clk);
		check(8'(n_rec - r), 8'h01);
		$display("test override done");
		tick(24);
		check({mode, source, valve, is_check}, st(ZSCS_HIGH, ZSCS_SRC_SCHED, 3'h1, 1'b1));
		check(8'(is_check), 8'h01);
		tick(1);
		check({mode, source, valve, is_check}, 8'h00);
		check(8'(valve_fault), 8'h00);
		$display("test sequence three done");
		end_sim();
	end
endmodule // zero_span_cal_sequencer_tb_top
